//--- prom_port_pkg.sv
// shared constants and carrier types for the nonvolatile-memory access port
package prom_port_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int LOW_ADDR_W = 8;
  localparam int HIGH_ADDR_W = 5;
  localparam int PORT_W = 8;
  // ---------------------------------------------------------------
  // strobe pin positions on the fifth general port
  // ---------------------------------------------------------------
  localparam int STROBE_PGM_BIT = 0;
  localparam int STROBE_OE_BIT = 1;
  localparam int STROBE_CE_BIT = 2;
  // strobes idle high, pins 4 and 3 tied high
  localparam logic [PORT_W-1:0] STROBE_PORT_IDLE = 8'h1F;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam int CLK_HZ = 10000000;
  localparam int PROG_PULSE_NS = 1000;
  localparam int PROG_CYCLES = (PROG_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int PROG_CNT_W = 8;

  typedef struct packed {
    logic chipSelectLow;
    logic outputGateLow;
    logic programStrobeLow;
  } strobes_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] enable;
  } data_drive_t;
endpackage : prom_port_pkg

//--- prom_cell_array.sv
// byte-wide nonvolatile cell array with one read and one program port
`timescale 1ns/1ps
module prom_cell_array
#(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 8
)
(
  input wire logic ref_clk,
  input wire logic [ADDR_W-1:0] readAddr,
  output logic [DATA_W-1:0] readData,
  input wire logic programEn,
  input wire logic [ADDR_W-1:0] programAddr,
  input wire logic [DATA_W-1:0] programData
);
  import prom_port_pkg::*;

  // erased cells read as all ones until programmed
  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1] = '{default: ERASED_BYTE};

  // programming only clears bits, as a real cell does
  always_ff @(posedge ref_clk)
  begin
    if (programEn)
    begin
      cells[programAddr] <= cells[programAddr] & programData;
    end
  end

  assign readData = cells[readAddr];
endmodule : prom_cell_array

//--- prom_access_port.sv
// parallel read and program port for the on-chip nonvolatile memory
`timescale 1ns/1ps
module prom_access_port
#(
  parameter int PROG_COUNT = prom_port_pkg::PROG_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic resetPinLow,
  input wire logic modeSupplyHigh,
  input wire logic [prom_port_pkg::PORT_W-1:0] firstGeneralPort,
  input wire logic [prom_port_pkg::PORT_W-1:0] secondGeneralPort,
  input wire logic [prom_port_pkg::PORT_W-1:0] thirdGeneralPortIn,
  output logic [prom_port_pkg::PORT_W-1:0] thirdGeneralPortOut,
  output logic [prom_port_pkg::PORT_W-1:0] thirdGeneralPortOe,
  input wire logic [prom_port_pkg::PORT_W-1:0] fifthGeneralPort,
  output logic accessMode,
  output logic programBusy
);
  import prom_port_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = 1 + 1 + PORT_W * 4;
  // strobes reset high, so no false falling edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {{(SYNC_W - PORT_W){1'b0}}, STROBE_PORT_IDLE};
  logic [SYNC_W-1:0] syncMeta;
  logic [SYNC_W-1:0] syncPins;
  logic [SYNC_W-1:0] next_syncMeta;
  logic [SYNC_W-1:0] next_syncPins;

  always_comb
  begin
    next_syncMeta = {resetPinLow, modeSupplyHigh, firstGeneralPort, secondGeneralPort,
                     thirdGeneralPortIn, fifthGeneralPort};
    next_syncPins = syncMeta;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      syncMeta <= SYNC_IDLE;
      syncPins <= SYNC_IDLE;
    end
    else
    begin
      syncMeta <= next_syncMeta;
      syncPins <= next_syncPins;
    end
  end

  logic modeReq;
  logic supplyOn;
  logic [PORT_W-1:0] addrLowPins;
  logic [PORT_W-1:0] addrHighPins;
  logic [PORT_W-1:0] dataPins;
  logic [PORT_W-1:0] strobePins;
  strobes_t strobes;
  logic [ADDR_W-1:0] memoryAddressLines;

  assign {modeReq, supplyOn, addrLowPins, addrHighPins, dataPins, strobePins} = syncPins;
  assign strobes.chipSelectLow = strobePins[STROBE_CE_BIT];
  assign strobes.outputGateLow = strobePins[STROBE_OE_BIT];
  assign strobes.programStrobeLow = strobePins[STROBE_PGM_BIT];
  // top three pins of the second port are tied high by the programmer
  assign memoryAddressLines = {addrHighPins[HIGH_ADDR_W-1:0], addrLowPins[LOW_ADDR_W-1:0]};

  // ---------------------------------------------------------------
  // mode, read path and program sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, PROGRAM, HOLD} prog_state_t;
  prog_state_t state;
  prog_state_t next_state;
  logic [PROG_CNT_W-1:0] count;
  logic [PROG_CNT_W-1:0] next_count;
  logic lastStrobe;
  logic next_lastStrobe;
  logic next_accessMode;
  logic next_programBusy;
  logic [ADDR_W-1:0] progAddr;
  logic [ADDR_W-1:0] next_progAddr;
  logic [DATA_W-1:0] progData;
  logic [DATA_W-1:0] next_progData;
  data_drive_t drive;
  data_drive_t next_drive;
  logic programEn;
  logic [DATA_W-1:0] cellData;
  logic readCond;
  logic writeCond;

  // the enable follows the sequencer, so a byte lands once per strobe
  assign programEn = (state == PROGRAM) && (count == '0) && accessMode;

  prom_cell_array #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cellArray (
    .ref_clk(ref_clk),
    .readAddr(memoryAddressLines),
    .readData(cellData),
    .programEn(programEn),
    .programAddr(progAddr),
    .programData(progData)
  );

  always_comb
  begin
    next_accessMode = modeReq;
    readCond = accessMode && !strobes.chipSelectLow && !strobes.outputGateLow
               && strobes.programStrobeLow;
    writeCond = accessMode && !strobes.chipSelectLow && strobes.outputGateLow
                && supplyOn;
    next_state = state;
    next_count = count;
    next_progAddr = progAddr;
    next_progData = progData;
    next_lastStrobe = strobes.programStrobeLow;
    next_drive.data = DATA_RESET;
    next_drive.enable = '0;
    if (readCond)
    begin
      next_drive.data = cellData;
      next_drive.enable = '1;
    end
    unique case (state)
      IDLE:
      begin
        // falling edge of the strobe while write conditions hold
        if (writeCond && lastStrobe && !strobes.programStrobeLow)
        begin
          next_progAddr = memoryAddressLines;
          next_progData = dataPins[DATA_W-1:0];
          next_count = PROG_CNT_W'(PROG_COUNT - 1);
          next_state = PROGRAM;
        end
      end
      PROGRAM:
      begin
        if (!accessMode)
        begin
          next_state = IDLE;
        end
        else if (count == '0)
        begin
          next_state = HOLD;
        end
        else
        begin
          next_count = count - PROG_CNT_W'(1);
        end
      end
      HOLD:
      begin
        // wait for strobe release so one pulse writes one byte
        if (strobes.programStrobeLow || !accessMode)
        begin
          next_state = IDLE;
        end
      end
    endcase
    next_programBusy = (next_state != IDLE);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= IDLE;
      count <= '0;
      lastStrobe <= 1'b1;
      accessMode <= 1'b0;
      programBusy <= 1'b0;
      progAddr <= '0;
      progData <= DATA_RESET;
      drive <= '0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      lastStrobe <= next_lastStrobe;
      accessMode <= next_accessMode;
      programBusy <= next_programBusy;
      progAddr <= next_progAddr;
      progData <= next_progData;
      drive <= next_drive;
    end
  end

  assign thirdGeneralPortOut = drive.data;
  assign thirdGeneralPortOe = drive.enable;
endmodule : prom_access_port

//--- prom_port_sva.sv
// assertions for the memory access port
`timescale 1ns/1ps
module prom_port_sva
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic resetPinLow,
  input wire logic modeSupplyHigh,
  input wire logic [prom_port_pkg::PORT_W-1:0] thirdGeneralPortOut,
  input wire logic [prom_port_pkg::PORT_W-1:0] thirdGeneralPortOe,
  input wire logic [prom_port_pkg::PORT_W-1:0] fifthGeneralPort,
  input wire logic accessMode,
  input wire logic programBusy
);
  import prom_port_pkg::*;
  // ----
  // strobes
  // ----
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire ce = fifthGeneralPort[STROBE_CE_BIT];
  wire oe = fifthGeneralPort[STROBE_OE_BIT];
  wire program_strobe_low = fifthGeneralPort[STROBE_PGM_BIT];
  wire wrOk = !ce && oe && modeSupplyHigh && accessMode;
  sequence rdHeld;
    (!ce && !oe && program_strobe_low && accessMode)[*5];
  endsequence
  sequence strobeIdle;
    program_strobe_low[*8];
  endsequence
  a_float_ctrl: assert property ((ce || oe)[*4] |-> thirdGeneralPortOe == 8'h00)
    else $error("bus driven with select or gate high");
  a_out_quiet: assert property (thirdGeneralPortOe == 8'h00 |-> thirdGeneralPortOut == 8'h00)
    else $error("data value shown while bus floats");
  a_read_drive: assert property (rdHeld |-> thirdGeneralPortOe == 8'hFF)
    else $error("read condition held but bus not driven");
  a_mode_enter: assert property (resetPinLow[*4] |-> accessMode)
    else $error("access mode not entered");
  a_mode_leave: assert property (!resetPinLow[*5] |-> !accessMode && !programBusy)
    else $error("access mode or programming kept after leaving");
  a_prog_cause: assert property ($rose(programBusy) |-> $past(wrOk, 2) && !$past(program_strobe_low, 2))
    else $error("programming started without write conditions");
  a_busy_ends: assert property (strobeIdle |-> !programBusy)
    else $error("programming busy with strobe idle");
  a_drive_mode: assert property (!accessMode[*2] |-> thirdGeneralPortOe == 8'h00)
    else $error("bus driven outside access mode");
endmodule : prom_port_sva
bind prom_access_port prom_port_sva prom_port_sva_inst (.ref_clk, .rst, .resetPinLow,
  .modeSupplyHigh, .thirdGeneralPortOut, .thirdGeneralPortOe, .fifthGeneralPort,
  .accessMode, .programBusy);

//--- prom_programmer.sv
// programmer-side pin model: fixed ties and data bus level
`timescale 1ns/1ps
module prom_programmer
(
  input wire logic ref_clk,
  input wire logic [prom_port_pkg::ADDR_W-1:0] addr,
  input wire prom_port_pkg::strobes_t ctl,
  input wire prom_port_pkg::data_drive_t drv,
  input wire logic [7:0] devOut,
  input wire logic [7:0] devOe,
  output logic [7:0] lowPort,
  output logic [7:0] highPort,
  output logic [7:0] ctlPort,
  output logic [7:0] busLevel
);
  import prom_port_pkg::*;
  logic [7:0] lastBus = 8'h00;
  assign lowPort = addr[7:0];
  assign highPort = {3'h7, addr[12:8]};
  assign ctlPort = {5'h03, ctl};
  // undriven bits toggle so a floating bus never looks like data
  always_comb
  begin
    busLevel = ~lastBus;
    for (int i = 0; i < 8; i++)
    begin
      if (devOe[i])
        busLevel[i] = devOut[i];
      else if (drv.enable[i])
        busLevel[i] = drv.data[i];
    end
  end
  always_ff @(posedge ref_clk) lastBus <= busLevel;
endmodule : prom_programmer

//--- tb_top.sv
// self-checking bench for the memory access port
`timescale 1ns/1ps
module tb_top;
  import prom_port_pkg::*;
  localparam int PC = 2;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic resetPinLow = 1'b0;
  logic modeSupplyHigh = 1'b0;
  logic [12:0] addr = 13'h0000;
  strobes_t ctl = 3'h7;
  data_drive_t drv = 16'h0000;
  logic [7:0] lowPort, highPort, ctlPort, busLevel, devOut, devOe, d, d2;
  logic accessMode, programBusy;
  logic prevOe = 1'b0;
  logic [7:0] expQ[$];
  logic [7:0] expV;
  logic [12:0] a;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  always #50 ref_clk = ~ref_clk;
  prom_programmer prom_programmer_inst (.ref_clk, .addr, .ctl, .drv, .devOut, .devOe,
    .lowPort, .highPort, .ctlPort, .busLevel);
  prom_access_port #(.PROG_COUNT(PC)) prom_access_port_inst (.ref_clk, .rst, .resetPinLow,
    .modeSupplyHigh, .firstGeneralPort(lowPort), .secondGeneralPort(highPort),
    .thirdGeneralPortIn(busLevel), .thirdGeneralPortOut(devOut),
    .thirdGeneralPortOe(devOe), .fifthGeneralPort(ctlPort), .accessMode, .programBusy);
  task automatic stop_test();
    // a read that never drove the bus leaves its note behind
    if (expQ.size() != 0)
    begin
      err_total++;
    end
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ctl is {select, gate, strobe}, all active low
  task automatic rd(input logic [12:0] ad, input logic [7:0] e);
    addr = ad;
    ctl = 3'h1;
    expQ.push_back(e);
    tick(7);
    ctl = 3'h7;
    tick(5);
  endtask : rd
  task automatic pr(input logic [12:0] ad, input logic [7:0] v);
    addr = ad;
    drv = {v, 8'hFF};
    ctl = 3'h3;
    tick(1);
    ctl = 3'h2;
    tick(PC + 8);
    chk(8'(programBusy), 8'(resetPinLow && modeSupplyHigh));
    ctl = 3'h3;
    tick(5);
    chk(8'(programBusy), 8'h00);
    drv = 16'h0000;
    ctl = 3'h7;
    tick(1);
  endtask : pr
  always @(negedge ref_clk)
  begin
    if (devOe === 8'hFF && !prevOe)
    begin
      comparisons++;
      expV = expQ.size() ? expQ.pop_front() : ~busLevel;
      if (busLevel !== expV)
      begin
        err_total++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, busLevel, expV);
      end
    end
    prevOe = (devOe === 8'hFF);
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(93806));
    tick(3);
    rst = 1'b0;
    modeSupplyHigh = 1'b1;
    a = 13'h1800 + 13'($urandom % 2048);
    d = 8'($urandom);
    pr(a, d);
    chk(8'(accessMode), 8'h00);
    resetPinLow = 1'b1;
    tick(5);
    chk(8'(accessMode), 8'h01);
    rd(a, ERASED_BYTE);
    pr(a, d);
    rd(a, d);
    d2 = 8'($urandom);
    pr(a, d2);
    d = d & d2;
    rd(a, d);
    modeSupplyHigh = 1'b0;
    pr(a, 8'h00);
    rd(a, d);
    modeSupplyHigh = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      a = 13'h0800 + 13'(i * 512 + $urandom % 512);
      d = 8'($urandom);
      pr(a, d);
      rd(a, d);
    end
    a = 13'($urandom % 2048);
    pr(a, 8'h00);
    rd(a, 8'h00);
    resetPinLow = 1'b0;
    tick(5);
    chk(8'(accessMode), 8'h00);
    stop_test();
  end
endmodule : tb_top
